//--- inc/gio_pkg.sv
// package: register map, field positions, reset values and carriers of the io port
package gio_pkg;

   // bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // register byte offsets
   localparam logic [ADDR_W-1:0] OFS_CLK_ENABLE  = 8'h50;
   localparam logic [ADDR_W-1:0] OFS_CLK_DISABLE = 8'h54;
   localparam logic [ADDR_W-1:0] OFS_CLK_STATUS  = 8'h58;
   localparam logic [ADDR_W-1:0] OFS_CONTROL     = 8'h60;
   localparam logic [ADDR_W-1:0] OFS_MODE        = 8'h64;
   localparam logic [ADDR_W-1:0] OFS_STATUS      = 8'h70;
   localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE  = 8'h74;
   localparam logic [ADDR_W-1:0] OFS_IRQ_DISABLE = 8'h78;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK    = 8'h7C;

   // field positions
   localparam int BIT_SOFT_RESET  = 0;
   localparam int BIT_PORT_CLK    = 0;
   localparam int BIT_CLK_OUT_SEL = 31;
   localparam int BIT_WAIT_SEL    = 30;
   localparam int PIN_CLK_OUT     = 31;
   localparam int PIN_WAIT        = 30;

   // reset values and writable bits
   localparam logic [DATA_W-1:0] MODE_RESET    = 32'h0000_0000;
   localparam logic [DATA_W-1:0] MODE_WRITABLE = 32'hC000_0000;
   localparam logic [DATA_W-1:0] STATUS_RESET  = 32'h0000_0000;
   localparam logic [DATA_W-1:0] MASK_RESET    = 32'h0000_0000;
   localparam logic [DATA_W-1:0] READ_ZERO     = 32'h0000_0000;
   localparam logic              CLK_EN_RESET  = 1'b1;

   // register port request
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wrData;
      logic              wrStb;
      logic              rdStb;
   } gio_bus_req_t;

   // pad mux controls for pins 31 and 30
   typedef struct packed {
      logic clkSel;
      logic pinOe_n;
      logic busWait_n;
   } gio_pin_mux_t;

endpackage

//--- core/gio_edge_detect.sv
// per-pin input synchroniser and change detector of the io port
`timescale 1ns/1ps
`default_nettype none

module gio_edge_detect #(
   parameter int NUM_PINS = 32
) (
   // clock and resets
   input  wire logic                clock,
   input  wire logic                reset_n,
   input  wire logic                clear,
   // port clock gate
   input  wire logic                enable,
   // pins
   input  wire logic [NUM_PINS-1:0] pinIn,
   // synchronised levels and change pulses
   output logic      [NUM_PINS-1:0] pinLevel,
   output logic      [NUM_PINS-1:0] pinChange
);

   logic [NUM_PINS-1:0] meta_r;
   logic [NUM_PINS-1:0] level_r;
   logic [NUM_PINS-1:0] prev_r;
   logic                primed_r;
   logic                primed_nxt;

   // first stage feeds only the second stage
   always_comb
   begin
      primed_nxt = clear ? 1'b0 : 1'b1;
   end

   // synchroniser and previous level run through reset, so a level held over reset is no change
   always_ff @(posedge clock)
   begin
      meta_r  <= pinIn;
      level_r <= meta_r;
      prev_r  <= level_r;
   end

   // priming flag masks change pulses until the first cycle after reset
   always_ff @(posedge clock)
   begin
      if (!reset_n)
         primed_r <= 1'b0;
      else
         primed_r <= primed_nxt;
   end

   // one change pulse per pin, either edge, only once primed and clocked
   genvar i;
   generate
      for (i = 0; i < NUM_PINS; i++)
      begin : g_pin
         assign pinChange[i] = primed_r & enable & (level_r[i] ^ prev_r[i]);
      end
   endgenerate

   assign pinLevel = level_r;

endmodule

`default_nettype wire

//--- core/gio_port_ctrl.sv
// io port control: soft reset, pin 31/30 muxing, change flags, change mask, clock status
`timescale 1ns/1ps
`default_nettype none

module gio_port_ctrl #(
   parameter int NUM_PINS = 32
) (
   // clock and reset
   input  wire logic                    clock,
   input  wire logic                    reset_n,
   // register port
   input  wire gio_pkg::gio_bus_req_t   busReq,
   output logic [gio_pkg::DATA_W-1:0]   rdData,
   // pins
   input  wire logic [NUM_PINS-1:0]     pinIn,
   output gio_pkg::gio_pin_mux_t        pinMux,
   // port clock state
   output logic                         portClkOn
);

   // register state
   logic [gio_pkg::DATA_W-1:0] modeReg_r;
   logic [gio_pkg::DATA_W-1:0] modeReg_nxt;
   logic [NUM_PINS-1:0]        status_r;
   logic [NUM_PINS-1:0]        status_nxt;
   logic [NUM_PINS-1:0]        mask_r;
   logic [NUM_PINS-1:0]        mask_nxt;
   logic                       clkEn_r;
   logic                       clkEn_nxt;
   logic [gio_pkg::DATA_W-1:0] rdData_r;
   logic [gio_pkg::DATA_W-1:0] rdData_nxt;
   gio_pkg::gio_pin_mux_t      pinMux_r;
   gio_pkg::gio_pin_mux_t      pinMux_nxt;

   // decoded strobes
   logic                       softRst;
   logic                       wrMode;
   logic                       wrIrqEn;
   logic                       wrIrqDis;
   logic                       wrClkEn;
   logic                       wrClkDis;
   logic                       rdStatus;

   // pin change detection
   logic [NUM_PINS-1:0]        pinLevel;
   logic [NUM_PINS-1:0]        pinChange;

   // write and read decode
   always_comb
   begin
      softRst  = busReq.wrStb && (busReq.addr == gio_pkg::OFS_CONTROL)
                 && busReq.wrData[gio_pkg::BIT_SOFT_RESET];
      wrMode   = busReq.wrStb && (busReq.addr == gio_pkg::OFS_MODE);
      wrIrqEn  = busReq.wrStb && (busReq.addr == gio_pkg::OFS_IRQ_ENABLE);
      wrIrqDis = busReq.wrStb && (busReq.addr == gio_pkg::OFS_IRQ_DISABLE);
      wrClkEn  = busReq.wrStb && (busReq.addr == gio_pkg::OFS_CLK_ENABLE);
      wrClkDis = busReq.wrStb && (busReq.addr == gio_pkg::OFS_CLK_DISABLE);
      rdStatus = busReq.rdStb && (busReq.addr == gio_pkg::OFS_STATUS);
   end

   // synchroniser and change detector, whose priming flag the soft reset clears
   gio_edge_detect #(
      .NUM_PINS (NUM_PINS)
   ) u_edge (
      .clock     (clock),
      .reset_n   (reset_n),
      .clear     (softRst),
      .enable    (clkEn_r),
      .pinIn     (pinIn),
      .pinLevel  (pinLevel),
      .pinChange (pinChange)
   );

   // next values of the port registers
   always_comb
   begin
      modeReg_nxt = modeReg_r;
      status_nxt  = status_r;
      mask_nxt    = mask_r;
      clkEn_nxt   = clkEn_r;
      // port clock gate survives the soft reset
      if (wrClkEn && busReq.wrData[gio_pkg::BIT_PORT_CLK])
         clkEn_nxt = 1'b1;
      if (wrClkDis && busReq.wrData[gio_pkg::BIT_PORT_CLK])
         clkEn_nxt = 1'b0;
      if (softRst)
      begin
         modeReg_nxt = gio_pkg::MODE_RESET;
         status_nxt  = gio_pkg::STATUS_RESET[NUM_PINS-1:0];
         mask_nxt    = gio_pkg::MASK_RESET[NUM_PINS-1:0];
      end
      else
      begin
         if (wrMode)
            modeReg_nxt = busReq.wrData & gio_pkg::MODE_WRITABLE;
         // a read clears what it returned; a change in the same cycle still sets
         if (rdStatus)
            status_nxt = '0;
         status_nxt = status_nxt | pinChange;
         if (wrIrqEn)
            mask_nxt = mask_nxt | busReq.wrData[NUM_PINS-1:0];
         if (wrIrqDis)
            mask_nxt = mask_nxt & ~busReq.wrData[NUM_PINS-1:0];
      end
   end

   // read data mux, valid only in the cycle after the read strobe
   always_comb
   begin
      rdData_nxt = gio_pkg::READ_ZERO;
      if (busReq.rdStb)
      begin
         unique case (busReq.addr)
            gio_pkg::OFS_MODE:
               rdData_nxt = modeReg_r;
            gio_pkg::OFS_STATUS:
               rdData_nxt[NUM_PINS-1:0] = status_r;
            gio_pkg::OFS_IRQ_MASK:
               rdData_nxt[NUM_PINS-1:0] = mask_r;
            gio_pkg::OFS_CLK_STATUS:
               rdData_nxt[gio_pkg::BIT_PORT_CLK] = clkEn_r;
            default:
               rdData_nxt = gio_pkg::READ_ZERO;
         endcase
      end
   end

   // pad mux controls follow the mode register in the same cycle
   always_comb
   begin
      pinMux_nxt.clkSel    = modeReg_nxt[gio_pkg::BIT_CLK_OUT_SEL];
      pinMux_nxt.pinOe_n   = ~modeReg_nxt[gio_pkg::BIT_CLK_OUT_SEL];
      pinMux_nxt.busWait_n = modeReg_nxt[gio_pkg::BIT_WAIT_SEL]
                             ? pinLevel[gio_pkg::PIN_WAIT] : 1'b1;
   end

   // register stage
   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         modeReg_r <= gio_pkg::MODE_RESET;
         status_r  <= gio_pkg::STATUS_RESET[NUM_PINS-1:0];
         mask_r    <= gio_pkg::MASK_RESET[NUM_PINS-1:0];
         clkEn_r   <= gio_pkg::CLK_EN_RESET;
         rdData_r  <= gio_pkg::READ_ZERO;
         pinMux_r  <= '{clkSel: 1'b0, pinOe_n: 1'b1, busWait_n: 1'b1};
      end
      else
      begin
         modeReg_r <= modeReg_nxt;
         status_r  <= status_nxt;
         mask_r    <= mask_nxt;
         clkEn_r   <= clkEn_nxt;
         rdData_r  <= rdData_nxt;
         pinMux_r  <= pinMux_nxt;
      end
   end

   // outputs straight from flip-flops
   assign rdData    = rdData_r;
   assign pinMux    = pinMux_r;
   assign portClkOn = clkEn_r;

   // checks
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);

   sequence seq_soft_reset;
      softRst;
   endsequence

   sequence seq_status_read;
      rdStatus;
   endsequence

   sequence seq_irq_enable;
      wrIrqEn && !softRst;
   endsequence

   // soft reset clears mode, mask and flags
   chk_soft_reset_clears: assert property (
      seq_soft_reset |=> (modeReg_r == gio_pkg::MODE_RESET) && (mask_r == '0)
                         && (status_r == '0) && !pinMux.clkSel && pinMux.busWait_n)
      else $error("soft reset left port state set");

   // soft reset leaves clock status alone
   chk_soft_reset_clock: assert property (
      seq_soft_reset |=> (clkEn_r == $past(clkEn_r)))
      else $error("soft reset changed clock status");

   // clock pin select and pad enable agree with the mode bit
   chk_clock_pin_mux: assert property (
      (pinMux.clkSel == modeReg_r[gio_pkg::BIT_CLK_OUT_SEL])
      && (pinMux.pinOe_n == !pinMux.clkSel))
      else $error("pin 31 clock mux out of step with mode");

   // wait routing follows the synchronised pin 30
   chk_wait_pin_route: assert property (
      ##1 (modeReg_r[gio_pkg::BIT_WAIT_SEL]
           ? (pinMux.busWait_n == $past(pinLevel[gio_pkg::PIN_WAIT]))
           : pinMux.busWait_n))
      else $error("bus wait routing wrong");

   // every detected change outside a soft reset cycle lands in the status register
   chk_change_sets_flag: assert property (
      (!softRst && |pinChange) |=> ((status_r & $past(pinChange)) == $past(pinChange)))
      else $error("pin change not flagged");

   // a status read returns the flags and clears them unless new changes arrive
   chk_status_read_clear: assert property (
      seq_status_read |=> (rdData[NUM_PINS-1:0] == $past(status_r))
                          && (status_r == $past(pinChange)))
      else $error("status read did not return and clear");

   // mask readback matches the mask
   chk_mask_readback: assert property (
      (busReq.rdStb && busReq.addr == gio_pkg::OFS_IRQ_MASK)
      |=> rdData[NUM_PINS-1:0] == $past(mask_r))
      else $error("mask readback wrong");

   // enable write sets only the written bits
   chk_enable_sets_mask: assert property (
      seq_irq_enable |=> (mask_r == ($past(mask_r) | $past(busReq.wrData[NUM_PINS-1:0]))))
      else $error("enable write did not set mask bits");

   // disable write clears only the written bits
   chk_disable_clears: assert property (
      (wrIrqDis && !softRst)
      |=> (mask_r == ($past(mask_r) & ~$past(busReq.wrData[NUM_PINS-1:0]))))
      else $error("disable write did not clear mask bits");

   // clock status readback in bit 0, other bits zero
   chk_clock_status_read: assert property (
      (busReq.rdStb && busReq.addr == gio_pkg::OFS_CLK_STATUS)
      |=> rdData == {31'h0000_0000, $past(clkEn_r)})
      else $error("clock status readback wrong");

endmodule

`default_nettype wire

//--- testbench/gio_pin_model.sv
// model of the outside circuitry that drives the port's input pins
`timescale 1ns/1ps
`default_nettype none

module gio_pin_model (
   // clock
   input  wire logic        clock,
   // toggle request from the bench
   input  wire logic [31:0] pinToggle,
   // pin levels seen by the port
   output var logic  [31:0] pinLevel
);
   // pins start low and flip where asked, just after a clock edge
   initial pinLevel = 32'h0000_0000;
   always @(posedge clock)
      pinLevel <= pinLevel ^ pinToggle;
endmodule

`default_nettype wire

//--- testbench/gio_port_ctrl_tb_top.sv
// self-checking bench of the io port control block
`timescale 1ns/1ps
`default_nettype none

module gio_port_ctrl_tb_top;
   // clock, reset, bus and pins
   logic                       clock = 1'b0;
   logic                       reset_n = 1'b0;
   gio_pkg::gio_bus_req_t      busReq = '0;
   logic [gio_pkg::DATA_W-1:0] rdData;
   logic [31:0]                pinIn;
   logic [31:0]                pinToggle = '0;
   gio_pkg::gio_pin_mux_t      pinMux;
   logic                       portClkOn;
   int                         fails = 0;
   int                         comparisons = 0;
   int                         cycles = 0;

   // 50 ns clock
   always #25 clock = ~clock;

   gio_port_ctrl i_dut (
      .clock     (clock),
      .reset_n   (reset_n),
      .busReq    (busReq),
      .rdData    (rdData),
      .pinIn     (pinIn),
      .pinMux    (pinMux),
      .portClkOn (portClkOn)
   );

   gio_pin_model i_pins (
      .clock     (clock),
      .pinToggle (pinToggle),
      .pinLevel  (pinIn)
   );

   // hang guard: the whole run needs under two hundred cycles
   always @(posedge clock)
   begin
      cycles <= cycles + 1;
      if (cycles == 3000)
      begin
         fails = fails + 1;
         test_done();
      end
   end

   // verdict and end of run
   task automatic test_done();
      if (fails == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // compare one value, report a mismatch at once
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         fails++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one-cycle register write
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      busReq <= '{addr: a, wrData: d, wrStb: 1'b1, rdStb: 1'b0};
      @(posedge clock);
      busReq.wrStb <= 1'b0;
      #1;
   endtask

   // one-cycle register read, data judged in the following cycle
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clock);
      busReq <= '{addr: a, wrData: '0, wrStb: 1'b0, rdStb: 1'b1};
      @(posedge clock);
      busReq.rdStb <= 1'b0;
      #1;
      check(rdData, exp);
   endtask

   // flip the given pins once, then let the synchroniser settle
   task automatic pins(input logic [31:0] m);
      @(posedge clock);
      pinToggle <= m;
      @(posedge clock);
      pinToggle <= '0;
      repeat (6) @(posedge clock);
      #1;
   endtask

   // values straight after reset
   task automatic t_reset();
      rd(gio_pkg::OFS_STATUS, 32'h0000_0000);
      rd(gio_pkg::OFS_IRQ_MASK, 32'h0000_0000);
      rd(gio_pkg::OFS_CLK_STATUS, 32'h0000_0001);
      check({29'h0, pinMux}, 32'h0000_0003);
   endtask

   // mask set and cleared bit by bit
   task automatic t_mask();
      wr(gio_pkg::OFS_IRQ_ENABLE, 32'hA5A5_0F0F);
      rd(gio_pkg::OFS_IRQ_MASK, 32'hA5A5_0F0F);
      wr(gio_pkg::OFS_IRQ_DISABLE, 32'h0000_0F00);
      wr(gio_pkg::OFS_IRQ_ENABLE, 32'h0000_0010);
      rd(gio_pkg::OFS_IRQ_MASK, 32'hA5A5_001F);
      rd(gio_pkg::OFS_IRQ_ENABLE, 32'h0000_0000);
      wr(gio_pkg::OFS_IRQ_DISABLE, 32'hFFFF_FFFF);
      rd(gio_pkg::OFS_IRQ_MASK, 32'h0000_0000);
   endtask

   // rising, falling and repeated changes, cleared by reading
   task automatic t_change();
      pins(32'h4000_0001);
      rd(gio_pkg::OFS_STATUS, 32'h4000_0001);
      rd(gio_pkg::OFS_STATUS, 32'h0000_0000);
      pins(32'h0000_0001);
      rd(gio_pkg::OFS_STATUS, 32'h0000_0001);
      pins(32'h0000_0100);
      pins(32'h0000_0100);
      rd(gio_pkg::OFS_STATUS, 32'h0000_0100);
      rd(gio_pkg::OFS_STATUS, 32'h0000_0000);
   endtask

   // clock out on pin 31 and bus wait from pin 30
   task automatic t_mode();
      wr(gio_pkg::OFS_MODE, 32'hFFFF_FFFF);
      rd(gio_pkg::OFS_MODE, 32'hC000_0000);
      @(posedge clock);
      #1;
      check(rdData, 32'h0000_0000);
      check({29'h0, pinMux}, 32'h0000_0005);
      pins(32'h4000_0000);
      check({29'h0, pinMux}, 32'h0000_0004);
      rd(gio_pkg::OFS_STATUS, 32'h4000_0000);
      wr(gio_pkg::OFS_MODE, 32'h0000_0000);
      repeat (2) @(posedge clock);
      #1;
      check({29'h0, pinMux}, 32'h0000_0003);
   endtask

   // soft reset clears the port but keeps the clock status
   task automatic t_soft();
      wr(gio_pkg::OFS_MODE, 32'hC000_0000);
      wr(gio_pkg::OFS_IRQ_ENABLE, 32'h0000_00FF);
      pins(32'h0000_0002);
      wr(gio_pkg::OFS_CLK_DISABLE, 32'h0000_0001);
      rd(gio_pkg::OFS_CLK_STATUS, 32'h0000_0000);
      check({31'h0, portClkOn}, 32'h0000_0000);
      wr(gio_pkg::OFS_CONTROL, 32'h0000_0000);
      rd(gio_pkg::OFS_MODE, 32'hC000_0000);
      wr(gio_pkg::OFS_CONTROL, 32'h0000_0001);
      rd(gio_pkg::OFS_MODE, 32'h0000_0000);
      rd(gio_pkg::OFS_IRQ_MASK, 32'h0000_0000);
      rd(gio_pkg::OFS_STATUS, 32'h0000_0000);
      rd(gio_pkg::OFS_CLK_STATUS, 32'h0000_0000);
      check({29'h0, pinMux}, 32'h0000_0003);
      wr(gio_pkg::OFS_CLK_ENABLE, 32'h0000_0001);
      rd(gio_pkg::OFS_CLK_STATUS, 32'h0000_0001);
      check({31'h0, portClkOn}, 32'h0000_0001);
   endtask

   // hardware reset in mid-run with pins 1 and 2 held high across it
   task automatic t_hw_reset();
      wr(gio_pkg::OFS_MODE, 32'hC000_0000);
      wr(gio_pkg::OFS_IRQ_ENABLE, 32'h0000_F000);
      pins(32'h0000_0004);
      wr(gio_pkg::OFS_CLK_DISABLE, 32'h0000_0001);
      @(posedge clock);
      reset_n <= 1'b0;
      repeat (2) @(posedge clock);
      reset_n <= 1'b1;
      repeat (6) @(posedge clock);
      #1;
      check({29'h0, pinMux}, 32'h0000_0003);
      check({31'h0, portClkOn}, 32'h0000_0001);
      rd(gio_pkg::OFS_STATUS, 32'h0000_0000);
      rd(gio_pkg::OFS_IRQ_MASK, 32'h0000_0000);
      rd(gio_pkg::OFS_MODE, 32'h0000_0000);
      rd(gio_pkg::OFS_CLK_STATUS, 32'h0000_0001);
   endtask

   // main sequence
   initial
   begin
      repeat (16) @(posedge clock);
      reset_n <= 1'b1;
      t_reset();
      t_mask();
      t_change();
      t_mode();
      t_soft();
      t_hw_reset();
      test_done();
   end
endmodule

`default_nettype wire
